/* File: rtl/crpa_arbiter.sv */
// Return path arbiter merging internal-bus and private DDR read returns into the core.
`timescale 1ns/1ps
module crpa_arbiter #(
   parameter int unsigned DATA_W = crpa_pkg::DATA_W
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ddr_port_en,
   input wire logic req_valid,
   input wire logic req_is_ddr,
   input wire logic [31:0] req_addr,
   input wire logic [3:0] req_len,
   output logic req_ready,
   output logic ibus_req_valid,
   output logic [31:0] ibus_req_addr,
   output logic [3:0] ibus_req_len,
   output logic ddr_req_valid,
   output logic [31:0] ddr_req_addr,
   output logic [3:0] ddr_req_len,
   input wire logic ibus_rd_valid,
   input wire logic [DATA_W-1:0] ibus_rd_data,
   output logic ibus_rd_ready,
   input wire logic ddr_rd_valid,
   input wire logic [DATA_W-1:0] ddr_rd_data,
   output logic ddr_rd_ready,
   output logic core_rd_valid,
   output logic [DATA_W-1:0] core_rd_data,
   output logic [2:0] core_rd_idx,
   output logic core_rd_from_ddr,
   output logic core_rd_last
);
   logic ib_busy;
   logic dd_busy;
   logic ib_last;
   logic dd_last;
   logic [2:0] ib_idx;
   logic [2:0] dd_idx;
   logic ib_take;
   logic dd_take;
   logic go_ddr;
   logic issue;
   logic ib_start;
   logic dd_start;

   logic ibv_ff;
   logic [31:0] iba_ff;
   logic [3:0] ibl_ff;
   logic ddv_ff;
   logic [31:0] dda_ff;
   logic [3:0] ddl_ff;
   logic nxt_ibv;
   logic [31:0] nxt_iba;
   logic [3:0] nxt_ibl;
   logic nxt_ddv;
   logic [31:0] nxt_dda;
   logic [3:0] nxt_ddl;

   logic cv_ff;
   logic [DATA_W-1:0] cd_ff;
   logic [2:0] ci_ff;
   logic cs_ff;
   logic cl_ff;
   logic nxt_cv;
   logic [DATA_W-1:0] nxt_cd;
   logic [2:0] nxt_ci;
   logic nxt_cs;
   logic nxt_cl;

   ////////////////////////////////////////////////////////////////////////////
   // One open transaction per path; a new request waits until its path retires.
   always_comb begin
      go_ddr = req_is_ddr && ddr_port_en;
      issue = req_valid && (go_ddr ? !dd_busy : !ib_busy);
      ib_start = issue && !go_ddr;
      dd_start = issue && go_ddr;
   end

   // Request registers to each path, one-cycle pulse per accepted request.
   always_comb begin
      nxt_ibv = ib_start;
      nxt_iba = ib_start ? req_addr : iba_ff;
      nxt_ibl = ib_start ? req_len : ibl_ff;
      nxt_ddv = dd_start;
      nxt_dda = dd_start ? req_addr : dda_ff;
      nxt_ddl = dd_start ? req_len : ddl_ff;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ibv_ff <= 1'b0;
         iba_ff <= 32'h0;
         ibl_ff <= 4'h0;
         ddv_ff <= 1'b0;
         dda_ff <= 32'h0;
         ddl_ff <= 4'h0;
      end else begin
         ibv_ff <= nxt_ibv;
         iba_ff <= nxt_iba;
         ibl_ff <= nxt_ibl;
         ddv_ff <= nxt_ddv;
         dda_ff <= nxt_dda;
         ddl_ff <= nxt_ddl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-path word tracking; the counters are independent so a stalled fill keeps its place.
   crpa_fill_tracker u_ib (
      .clock(clock),
      .rst_b(rst_b),
      .start(ib_start),
      .crit_idx(req_addr[4:2]),
      .start_len(req_len),
      .word_done(ib_take),
      .busy(ib_busy),
      .cur_idx(ib_idx),
      .last(ib_last)
   );

   crpa_fill_tracker u_dd (
      .clock(clock),
      .rst_b(rst_b),
      .start(dd_start),
      .crit_idx(req_addr[4:2]),
      .start_len(req_len),
      .word_done(dd_take),
      .busy(dd_busy),
      .cur_idx(dd_idx),
      .last(dd_last)
   );

   ////////////////////////////////////////////////////////////////////////////
   // DDR wins; the internal bus is only held off, never dropped, so its words wait upstream.
   always_comb begin
      dd_take = ddr_rd_valid && dd_busy;
      ib_take = ibus_rd_valid && ib_busy && !dd_take;
      ddr_rd_ready = dd_busy;
      ibus_rd_ready = ib_busy && !dd_take;
   end

   // Core return register; the data mux follows the single winner so streams never mix.
   always_comb begin
      nxt_cv = dd_take || ib_take;
      nxt_cd = dd_take ? ddr_rd_data : (ib_take ? ibus_rd_data : cd_ff);
      nxt_ci = dd_take ? dd_idx : (ib_take ? ib_idx : ci_ff);
      nxt_cs = dd_take;
      nxt_cl = dd_take ? dd_last : (ib_take && ib_last);
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cv_ff <= 1'b0;
         cd_ff <= '0;
         ci_ff <= 3'h0;
         cs_ff <= 1'b0;
         cl_ff <= 1'b0;
      end else begin
         cv_ff <= nxt_cv;
         cd_ff <= nxt_cd;
         ci_ff <= nxt_ci;
         cs_ff <= nxt_cs;
         cl_ff <= nxt_cl;
      end
   end

   assign req_ready = issue;
   assign ibus_req_valid = ibv_ff;
   assign ibus_req_addr = iba_ff;
   assign ibus_req_len = ibl_ff;
   assign ddr_req_valid = ddv_ff;
   assign ddr_req_addr = dda_ff;
   assign ddr_req_len = ddl_ff;
   assign core_rd_valid = cv_ff;
   assign core_rd_data = cd_ff;
   assign core_rd_idx = ci_ff;
   assign core_rd_from_ddr = cs_ff;
   assign core_rd_last = cl_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks beside the logic.
   sequence s_both_arrive;
      ibus_rd_valid && ib_busy && ddr_rd_valid && dd_busy;
   endsequence

   a_ddr_wins_port: assert property (@(posedge clock) disable iff (!rst_b)
      s_both_arrive |=> core_rd_valid && core_rd_from_ddr)
      else $error("DDR return did not win the core port.");

   a_ddr_data_clean: assert property (@(posedge clock) disable iff (!rst_b)
      (ib_take) |=> (core_rd_data == $past(ibus_rd_data)) && !core_rd_from_ddr)
      else $error("Internal-bus word mixed with DDR data.");

   a_no_ibus_drop: assert property (@(posedge clock) disable iff (!rst_b)
      (ibus_rd_valid && dd_take) |-> !ibus_rd_ready)
      else $error("Internal-bus word accepted while preempted.");

   a_route_disabled: assert property (@(posedge clock) disable iff (!rst_b)
      (issue && !ddr_port_en) |=> ibus_req_valid && !ddr_req_valid)
      else $error("Request used the private port while disabled.");

   a_route_ddr: assert property (@(posedge clock) disable iff (!rst_b)
      (issue && req_is_ddr && ddr_port_en) |=> ddr_req_valid && !ibus_req_valid)
      else $error("DDR request not routed to the private port.");

   a_crit_first: assert property (@(posedge clock) disable iff (!rst_b)
      ib_start |=> ib_busy && (ib_idx == $past(req_addr[4:2])))
      else $error("Fill did not start at the critical word.");

   a_retire_last: assert property (@(posedge clock) disable iff (!rst_b)
      (ib_take && ib_last) |=> !ib_busy && core_rd_last)
      else $error("Fill not retired on its last word.");

   a_busy_holds: assert property (@(posedge clock) disable iff (!rst_b)
      (ib_busy && !ib_take) |=> ib_busy)
      else $error("Fill retired without delivering its words.");
endmodule // crpa_arbiter

/* File: rtl/crpa_fill_tracker.sv */
// Word tracker for one return path: holds the open fill and counts returned words.
`timescale 1ns/1ps
module crpa_fill_tracker #(
   parameter int unsigned LINE_WORDS = crpa_pkg::LINE_WORDS
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic start,
   input wire logic [crpa_pkg::WORD_IDX_W-1:0] crit_idx,
   input wire logic [3:0] start_len,
   input wire logic word_done,
   output logic busy,
   output logic [crpa_pkg::WORD_IDX_W-1:0] cur_idx,
   output logic last
);
   logic busy_ff;
   logic nxt_busy;
   logic [crpa_pkg::WORD_IDX_W-1:0] idx_ff;
   logic [crpa_pkg::WORD_IDX_W-1:0] nxt_idx;
   logic [3:0] left_ff;
   logic [3:0] nxt_left;

   ////////////////////////////////////////////////////////////////////////////
   // The word index wraps so that the critical word leaves first.
   always_comb begin
      nxt_busy = busy_ff;
      nxt_idx = idx_ff;
      nxt_left = left_ff;
      if (start && !busy_ff) begin
         nxt_busy = 1'b1;
         nxt_idx = crit_idx;
         nxt_left = start_len;
      end else if (word_done && busy_ff) begin
         nxt_idx = idx_ff + 3'h1;
         nxt_left = left_ff - 4'h1;
         if (left_ff == 4'h1) begin
            nxt_busy = 1'b0;
         end
      end
   end

   // Registers only.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         busy_ff <= 1'b0;
         idx_ff <= 3'h0;
         left_ff <= 4'h0;
      end else begin
         busy_ff <= nxt_busy;
         idx_ff <= nxt_idx;
         left_ff <= nxt_left;
      end
   end

   assign busy = busy_ff;
   assign cur_idx = idx_ff;
   assign last = busy_ff && (left_ff == 4'h1);
endmodule // crpa_fill_tracker

/* File: rtl/crpa_pkg.sv */
// Package of shared constants and types for the core return path arbiter.
package crpa_pkg;
   // Words in one cache line fill.
   localparam int unsigned LINE_WORDS = 8;
   localparam int unsigned WORD_IDX_W = 3;
   // Data word width of the core return port.
   localparam int unsigned DATA_W = 32;
   // Return sources seen by the core port.
   typedef enum logic [1:0] {
      CRPA_SRC_NONE,
      CRPA_SRC_IBUS,
      CRPA_SRC_DDR
   } crpa_src_t;
endpackage

/* File: sim/core_return_path_arbiter_test.sv */
// Self-checking testbench of the core return path arbiter.
`timescale 1ns/1ps
module core_return_path_arbiter_test;
   typedef struct packed {logic d; logic en; logic [31:0] a; logic [3:0] n;} crpa_row_t;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic ddr_port_en = 1'b1;
   logic req_valid = 1'b0;
   logic req_is_ddr = 1'b0;
   logic [31:0] req_addr = 32'h0;
   logic [3:0] req_len = 4'h1;
   logic [3:0] dly_ibus = 4'h0;
   logic [3:0] dly_ddr = 4'h0;
   logic req_ready, ibus_req_valid, ddr_req_valid, ibus_rd_valid, ibus_rd_ready, ddr_rd_valid, ddr_rd_ready;
   logic [31:0] ibus_req_addr, ddr_req_addr, ibus_rd_data, ddr_rd_data, core_rd_data;
   logic [3:0] ibus_req_len, ddr_req_len;
   logic core_rd_valid, core_rd_from_ddr, core_rd_last, ms;
   logic [2:0] core_rd_idx;
   logic [3:0] exp_left[2] = '{4'h0, 4'h0};
   logic [2:0] exp_idx[2] = '{3'h0, 3'h0};
   int checks = 0;
   int bad_count = 0;
   crpa_row_t rows[6] = '{'{0, 1, 32'h0, 8}, '{0, 1, 32'h14, 8}, '{1, 1, 32'h1C, 3},
                          '{1, 0, 32'h08, 8}, '{1, 1, 32'h10, 1}, '{1, 1, 32'h04, 8}};
   crpa_arbiter i_dut (.clock(clock), .rst_b(rst_b), .ddr_port_en(ddr_port_en), .req_valid(req_valid),
      .req_is_ddr(req_is_ddr), .req_addr(req_addr), .req_len(req_len), .req_ready(req_ready),
      .ibus_req_valid(ibus_req_valid), .ibus_req_addr(ibus_req_addr), .ibus_req_len(ibus_req_len),
      .ddr_req_valid(ddr_req_valid), .ddr_req_addr(ddr_req_addr), .ddr_req_len(ddr_req_len),
      .ibus_rd_valid(ibus_rd_valid), .ibus_rd_data(ibus_rd_data), .ibus_rd_ready(ibus_rd_ready),
      .ddr_rd_valid(ddr_rd_valid), .ddr_rd_data(ddr_rd_data), .ddr_rd_ready(ddr_rd_ready),
      .core_rd_valid(core_rd_valid), .core_rd_data(core_rd_data), .core_rd_idx(core_rd_idx),
      .core_rd_from_ddr(core_rd_from_ddr), .core_rd_last(core_rd_last));
   crpa_path_model #(.TAG(8'hA0)) i_ibus (.clock(clock), .rst_b(rst_b), .req_valid(ibus_req_valid),
      .req_addr(ibus_req_addr), .req_len(ibus_req_len), .delay(dly_ibus), .rd_ready(ibus_rd_ready),
      .rd_valid(ibus_rd_valid), .rd_data(ibus_rd_data));
   crpa_path_model #(.TAG(8'hD0)) i_ddr (.clock(clock), .rst_b(rst_b), .req_valid(ddr_req_valid),
      .req_addr(ddr_req_addr), .req_len(ddr_req_len), .delay(dly_ddr), .rd_ready(ddr_rd_ready),
      .rd_valid(ddr_rd_valid), .rd_data(ddr_rd_data));
   // Free-running 200 MHz clock.
   always #2.5 clock = ~clock;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Holds the request until accepted, then checks which path received it.
   task automatic req(input logic d, input logic en, input logic [31:0] a, input logic [3:0] n);
      int i;
      logic s;
      s = d & en;
      ddr_port_en <= en;
      req_valid <= 1'b1;
      req_is_ddr <= d;
      req_addr <= a;
      req_len <= n;
      i = 0;
      do begin
         @(posedge clock);
         i++;
      end while (req_ready !== 1'b1 && i < 100);
      exp_idx[s] = a[4:2];
      exp_left[s] = n;
      req_valid <= 1'b0;
      @(posedge clock);
      chk({ibus_req_valid, ddr_req_valid}, {~s, s});
      chk(s ? ddr_req_len : ibus_req_len, n);
      chk(s ? ddr_req_addr : ibus_req_addr, a);
   endtask
   // Waits a bounded time for every expected word, then insists none is missing.
   task automatic wait_idle;
      for (int i = 0; i < 200 && (exp_left[0] != 4'h0 || exp_left[1] != 4'h0); i++) @(posedge clock);
      chk({exp_left[1], exp_left[0]}, 0);
   endtask
   // Each core word must match the next word of its own stream, never the other's.
   always @(posedge clock) begin
      if (rst_b === 1'b1 && core_rd_valid === 1'b1) begin
         ms = (core_rd_from_ddr === 1'b1);
         chk(exp_left[ms] != 4'h0, 1);
         chk(core_rd_idx, exp_idx[ms]);
         chk(core_rd_data, {ms ? 8'hD0 : 8'hA0, 21'h0, exp_idx[ms]});
         chk(core_rd_last, exp_left[ms] == 4'h1);
         exp_idx[ms] = exp_idx[ms] + 3'h1;
         exp_left[ms] = exp_left[ms] - 4'h1;
      end
      if (ddr_rd_valid === 1'b1 && ddr_rd_ready === 1'b1 && ibus_rd_valid === 1'b1) chk(ibus_rd_ready, 0);
   end
   // Cuts a hang short well past the expected run length.
   initial begin
      repeat (20000) @(posedge clock);
      bad_count++;
      test_done;
   end
   // Table rows first, then collisions and a reset in mid-fill.
   initial begin
      repeat (16) @(posedge clock);
      rst_b <= 1'b1;
      foreach (rows[r]) begin
         req(rows[r].d, rows[r].en, rows[r].a, rows[r].n);
         wait_idle;
      end
      for (int k = 0; k < 3; k++) begin
         dly_ibus <= k[3:0];
         req(0, 1, 32'h0C, 8);
         req(1, 1, 32'h00, 8);
         wait_idle;
      end
      dly_ddr <= 4'h3;
      req(1, 1, 32'h18, 5);
      req(0, 1, 32'h1C, 8);
      wait_idle;
      req(0, 1, 32'h04, 8);
      repeat (3) @(posedge clock);
      rst_b <= 1'b0;
      @(posedge clock);
      chk({core_rd_valid, ibus_req_valid, ddr_req_valid}, 0);
      exp_left = '{4'h0, 4'h0};
      rst_b <= 1'b1;
      req(1, 1, 32'h1C, 4);
      wait_idle;
      test_done;
   end
endmodule // core_return_path_arbiter_test

/* File: sim/crpa_path_model.sv */
// Behavioural far-side model of one return path, either the internal bus or the DDR controller.
`timescale 1ns/1ps
module crpa_path_model #(
   parameter logic [7:0] TAG = 8'hA0
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic req_valid,
   input wire logic [31:0] req_addr,
   input wire logic [3:0] req_len,
   input wire logic [3:0] delay,
   input wire logic rd_ready,
   output logic rd_valid,
   output logic [31:0] rd_data
);
   logic [3:0] left_ff;
   logic [3:0] wait_ff;
   logic [2:0] idx_ff;
   logic [31:0] last_ff;
   // Between words the data lines flip, so that a stale word can never pass for a fresh one.
   assign rd_valid = (left_ff != 4'h0) && (wait_ff == 4'h0);
   assign rd_data = rd_valid ? {TAG, 21'h0, idx_ff} : ~last_ff;
   // Words leave in wrap order from the critical index and are held until taken.
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         left_ff <= 4'h0;
         wait_ff <= 4'h0;
         idx_ff <= 3'h0;
         last_ff <= 32'h0;
      end else if (req_valid) begin
         left_ff <= req_len;
         idx_ff <= req_addr[4:2];
         wait_ff <= delay;
      end else if (rd_valid && rd_ready) begin
         left_ff <= left_ff - 4'h1;
         idx_ff <= idx_ff + 3'h1;
         wait_ff <= delay;
         last_ff <= rd_data;
      end else if (wait_ff != 4'h0) begin
         wait_ff <= wait_ff - 4'h1;
      end
   end
endmodule // crpa_path_model
